// ### hdl/sbc_irq_pkg.sv
// Purpose: constants and types shared by the interrupt logic
// Assumes: 200 MHz system clock
// Notes: flag vectors use the index constants below
package sbc_irq_pkg;

    // ****************************************************************
    // sizes and indices
    // ****************************************************************
    localparam int WAKE_N = 4;
    localparam int STATE_N = 8;
    localparam int FAIL_N = 3;
    localparam int SRC_N = WAKE_N + STATE_N + FAIL_N;
    localparam int CNT_W = 21;

    // wake flags, register 000
    localparam int IDX_BUS_WAKE = 0;
    localparam int IDX_SINGLE_WIRE_WAKE = 1;
    localparam int IDX_PIN_WAKE = 2;
    localparam int IDX_PERIODIC_WAKE = 3;
    // condition flags, register 001
    localparam int IDX_MAIN_REG_OVERTEMP_WARN = 0;
    localparam int IDX_AUX_REG_OVERTEMP = 1;
    localparam int IDX_TRANSCEIVER_OVERTEMP = 2;
    localparam int IDX_BUS_FAIL = 3;
    localparam int IDX_SINGLE_WIRE_FAIL = 4;
    localparam int IDX_AUX_REG_UNDERVOLT = 5;
    localparam int IDX_THIRD_REG_UNDERVOLT = 6;
    localparam int IDX_THIRD_REG_OVERCURRENT = 7;
    // internal failure flags, register 010
    localparam int IDX_SPI_CORRUPT = 0;
    localparam int IDX_RESET_EVENT = 1;
    localparam int IDX_WATCHDOG_CONFIG_ERROR = 2;

    // condition flags sensitive to both edges
    localparam logic [STATE_N-1:0] BOTH_EDGE_MASK = 8'h60;
    localparam logic [SRC_N-1:0] MASK_RESET = 15'h7FFF;

    // ****************************************************************
    // register addresses and commands
    // ****************************************************************
    localparam logic [2:0] ADDR_WAKE_SUMMARY = 3'h0;
    localparam logic [2:0] ADDR_CONDITION = 3'h1;
    localparam logic [2:0] ADDR_FAILURE = 3'h2;
    localparam logic [2:0] CMD_READ_ONLY = 3'h7;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_MHZ = 200;
    localparam int IRQ_MIN_PULSE_NS = 10000;
    localparam int IRQ_TIMEOUT_US = 6000;
    // least time: round up
    localparam int IRQ_MIN_PULSE_CYC =
        (IRQ_MIN_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int IRQ_TIMEOUT_CYC = IRQ_TIMEOUT_US * CLK_MHZ;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [2:0] {
        MODE_INIT = 3'b000,
        MODE_NORMAL = 3'b001,
        MODE_STOP = 3'b010,
        MODE_SLEEP = 3'b011,
        MODE_RESTART = 3'b100,
        MODE_FAILSAFE = 3'b101,
        MODE_FLASH = 3'b110
    } sys_mode_type;

    typedef enum logic [1:0] {
        PIN_IDLE = 2'b00,
        PIN_LOW = 2'b01,
        PIN_GAP = 2'b10
    } pin_state_type;

endpackage

// ### hdl/irq_pulse_timer.sv
// Purpose: saturating cycle counter that times the interrupt phases
// Assumes: clear has priority over counting
// Notes: holds at its maximum value
`timescale 1ns/1ps
module irq_pulse_timer #(
    parameter int CNT_W = 21
) (
    input wire logic clk_sys,            // system clock
    input wire logic rst_n,              // synchronous reset, low
    input wire logic clear,              // restart from zero
    output logic [CNT_W-1:0] count       // cycles since clear
);
    logic [CNT_W-1:0] countQ;
    logic [CNT_W-1:0] countD;

    always_comb begin
        if (clear) begin
            countD = '0;
        end else if (&countQ) begin
            countD = countQ;
        end else begin
            countD = countQ + 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            countQ <= '0;
        end else begin
            countQ <= countD;
        end
    end

    assign count = countQ;
endmodule

// ### hdl/sbc_interrupt_logic.sv
// Purpose: maskable latched interrupt flags and the active-low irq pin
// Assumes: inputs synchronous to clk_sys; event inputs are pulses
// Notes: pin is open drain, driven low only while irqPinOe is high
`timescale 1ns/1ps
module sbc_interrupt_logic #(
    parameter int TIMEOUT_CYC = sbc_irq_pkg::IRQ_TIMEOUT_CYC
) (
    input wire logic clk_sys,                       // system clock
    input wire logic rst_n,                         // sync reset, low
    input sbc_irq_pkg::sys_mode_type sysMode,       // current system mode
    input wire logic reset_out_n,                   // reset output level
    input wire logic [sbc_irq_pkg::WAKE_N-1:0] wakeEvt,   // wake pulses
    input wire logic [sbc_irq_pkg::STATE_N-1:0] condIn,   // fault levels
    input wire logic [sbc_irq_pkg::FAIL_N-1:0] failEvt,   // failure pulses
    input wire logic auxRegSwitchOn,                // aux on command pulse
    input wire logic auxRegSwitchingOff,            // aux being switched off
    input wire logic thirdRegSwitchOn,              // third on command pulse
    input wire logic thirdRegSwitchingOff,          // third being switched off
    input wire logic thirdRegInhibit,               // overcurrent inhibited
    input wire logic maskWrite,                     // load mask pulse
    input wire logic [sbc_irq_pkg::SRC_N-1:0] maskData, // new mask bits
    input wire logic rdStrobe,                      // spi access pulse
    input wire logic [2:0] rdCmd,                   // spi command code
    input wire logic [2:0] rdAddr,                  // spi register address
    input wire logic irqPinIn,                      // pin level read back
    output logic irqPinOut,                         // pin drive value
    output logic irqPinOe,                          // pin driven low
    output logic cfgSel,                            // 0 cfg 1/3, 1 cfg 2/4
    output logic [sbc_irq_pkg::SRC_N-1:0] maskOut,  // current masks
    output logic [sbc_irq_pkg::WAKE_N-1:0] wakeFlags,   // register 000
    output logic summaryFlag,                       // register 000 summary
    output logic [sbc_irq_pkg::STATE_N-1:0] condFlags,  // register 001
    output logic [sbc_irq_pkg::FAIL_N-1:0] failFlags    // register 010
);
    import sbc_irq_pkg::*;

    localparam logic [CNT_W-1:0] MIN_LAST = CNT_W'(IRQ_MIN_PULSE_CYC - 1);
    localparam logic [CNT_W-1:0] TO_LAST = CNT_W'(TIMEOUT_CYC - 1);

    // ****************************************************************
    // flag state
    // ****************************************************************
    logic [STATE_N-1:0] prevQ, prevD;
    logic [STATE_N-1:0] condQ, condD;
    logic [WAKE_N-1:0] wakeQ, wakeD;
    logic [FAIL_N-1:0] failQ, failD;
    logic summaryQ, summaryD;
    logic [SRC_N-1:0] maskQ, maskD;
    logic cfgQ, cfgD;
    logic [STATE_N-1:0] condNow, stateEvt, suppress, switchOn;
    logic [SRC_N-1:0] srcEvt;
    logic readOnly, clr000, clr001, clr010;
    logic modeOk, initPhase, req;

    always_comb begin
        condNow = condIn;
        condNow[IDX_THIRD_REG_OVERCURRENT] =
            condIn[IDX_THIRD_REG_OVERCURRENT] & ~thirdRegInhibit;
        suppress = '0;
        suppress[IDX_AUX_REG_UNDERVOLT] = auxRegSwitchingOff;
        suppress[IDX_THIRD_REG_UNDERVOLT] = thirdRegSwitchingOff;
        switchOn = '0;
        switchOn[IDX_AUX_REG_UNDERVOLT] = auxRegSwitchOn;
        switchOn[IDX_THIRD_REG_UNDERVOLT] = thirdRegSwitchOn;
        // rising edges, plus falling edges of undervoltage
        stateEvt = ((condNow & ~prevQ)
            | (~condNow & prevQ & BOTH_EDGE_MASK)) & ~suppress;
        stateEvt = stateEvt | switchOn;
        srcEvt = {failEvt, stateEvt, wakeEvt};
        modeOk = (sysMode == MODE_NORMAL) || (sysMode == MODE_STOP);
        initPhase = (sysMode == MODE_INIT) && !reset_out_n;
        req = modeOk && ((srcEvt & maskQ) != '0);
        readOnly = rdStrobe && (rdCmd == CMD_READ_ONLY);
        clr000 = readOnly && (rdAddr == ADDR_WAKE_SUMMARY);
        clr001 = readOnly && (rdAddr == ADDR_CONDITION);
        clr010 = readOnly && (rdAddr == ADDR_FAILURE);

        prevD = condNow;
        // set wins over clear; after a read the flag follows condition
        condD = stateEvt | condNow | (condQ & ~{STATE_N{clr001}});
        failD = failEvt | (failQ & ~{FAIL_N{clr010}});
        wakeD = wakeEvt | (wakeQ & ~{WAKE_N{clr000}});
        summaryD = (condD != '0) || (failD != '0);
        if (sysMode == MODE_RESTART) begin
            maskD = MASK_RESET;
        end else if (maskWrite) begin
            maskD = maskData;
        end else begin
            maskD = maskQ;
        end
        cfgD = initPhase ? irqPinIn : cfgQ;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            prevQ <= '0;
            condQ <= '0;
            wakeQ <= '0;
            failQ <= '0;
            summaryQ <= 1'b0;
            maskQ <= MASK_RESET;
            cfgQ <= 1'b0;
        end else begin
            prevQ <= prevD;
            condQ <= condD;
            wakeQ <= wakeD;
            failQ <= failD;
            summaryQ <= summaryD;
            maskQ <= maskD;
            cfgQ <= cfgD;
        end
    end

    // ****************************************************************
    // pin sequencer
    // ****************************************************************
    pin_state_type stateQ, stateD;
    logic pendQ, pendD;
    logic relQ, relD;
    logic tmrClear;
    logic [CNT_W-1:0] tmrCount;

    irq_pulse_timer #(
        .CNT_W(CNT_W)
    ) u_timer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clear(tmrClear),
        .count(tmrCount)
    );

    always_comb begin
        stateD = stateQ;
        tmrClear = 1'b0;
        // events while low merge into the current pulse
        pendD = pendQ | (req && stateQ != PIN_LOW);
        relD = relQ | (clr000 && stateQ == PIN_LOW);
        case (stateQ)
            PIN_IDLE: begin
                if ((pendQ || req) && modeOk && !initPhase) begin
                    stateD = PIN_LOW;
                    tmrClear = 1'b1;
                    pendD = 1'b0;
                end
            end
            PIN_LOW: begin
                if (((relQ || clr000) && tmrCount >= MIN_LAST)
                        || tmrCount >= TO_LAST) begin
                    stateD = PIN_GAP;
                    tmrClear = 1'b1;
                    relD = 1'b0;
                end
            end
            PIN_GAP: begin
                if (tmrCount >= TO_LAST) begin
                    stateD = PIN_IDLE;
                    tmrClear = 1'b1;
                end
            end
            default: begin
                stateD = PIN_IDLE;
                tmrClear = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            stateQ <= PIN_IDLE;
            pendQ <= 1'b0;
            relQ <= 1'b0;
        end else begin
            stateQ <= stateD;
            pendQ <= pendD;
            relQ <= relD;
        end
    end

    assign irqPinOut = 1'b0;
    assign irqPinOe = (stateQ == PIN_LOW) && !initPhase;
    assign cfgSel = cfgQ;
    assign maskOut = maskQ;
    assign wakeFlags = wakeQ;
    assign summaryFlag = summaryQ;
    assign condFlags = condQ;
    assign failFlags = failQ;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_masked_no_req: assert property (
        stateQ == PIN_IDLE && !pendQ && (srcEvt & maskQ) == '0
            |=> stateQ != PIN_LOW)
        else $error("masked source raised a request");
    a_mode_gate: assert property (
        stateQ == PIN_IDLE && !modeOk |=> stateQ != PIN_LOW)
        else $error("pin asserted outside normal or stop");
    a_min_pulse_width: assert property (
        stateQ == PIN_LOW && stateD == PIN_GAP
            |-> tmrCount >= MIN_LAST)
        else $error("low pulse shorter than minimum");
    a_low_timeout: assert property (
        stateQ == PIN_LOW |-> tmrCount <= TO_LAST)
        else $error("pin low beyond timeout");
    a_gap_spacing: assert property (
        stateQ == PIN_LOW ##1 stateQ == PIN_GAP
            |-> !irqPinOe [*8])
        else $error("pin reasserted inside gap");
    a_restart_masks: assert property (
        sysMode == MODE_RESTART |=> maskQ == MASK_RESET)
        else $error("masks not enabled after restart");
    a_wake_clear: assert property (
        clr000 && wakeEvt == '0 |=> wakeFlags == '0)
        else $error("wake flags not cleared by read");
    a_summary_zero: assert property (
        ##1 (condQ == '0 && failQ == '0) |-> !summaryQ)
        else $error("summary set with empty registers");
    a_switch_on_flag: assert property (
        auxRegSwitchOn |=> condQ[IDX_AUX_REG_UNDERVOLT])
        else $error("switch-on did not set undervolt flag");
    a_switch_off_quiet: assert property (
        auxRegSwitchingOff && !auxRegSwitchOn
            |-> !stateEvt[IDX_AUX_REG_UNDERVOLT])
        else $error("switch-off undervoltage raised event");
    a_config_input: assert property (
        initPhase |-> !irqPinOe)
        else $error("pin driven during configuration phase");
    a_latch_hold: assert property (
        condQ[IDX_AUX_REG_OVERTEMP] && !clr001
            |=> condQ[IDX_AUX_REG_OVERTEMP])
        else $error("condition flag dropped before read");
    a_pend_serviced: assert property (
        stateQ == PIN_IDLE && pendQ && modeOk && !initPhase
            |=> stateQ == PIN_LOW)
        else $error("pending interrupt not asserted after gap");
    a_gap_stores: assert property (
        stateQ == PIN_GAP && req
            |=> pendQ)
        else $error("interrupt in gap not stored");
    a_low_merges: assert property (
        stateQ == PIN_LOW && req && !pendQ
            |=> !pendQ)
        else $error("event while low queued a second pulse");
    a_read_release: assert property (
        stateQ == PIN_LOW && relQ && tmrCount >= MIN_LAST
            |=> stateQ == PIN_GAP)
        else $error("pin not released after read");
    a_timeout_release: assert property (
        stateQ == PIN_LOW && tmrCount >= TO_LAST
            |=> stateQ == PIN_GAP)
        else $error("pin not released at timeout");
    a_req_asserts: assert property (
        stateQ == PIN_IDLE && req && !initPhase
            |=> stateQ == PIN_LOW)
        else $error("enabled source did not assert pin");
    a_fail_set: assert property (
        failEvt[IDX_SPI_CORRUPT]
            |=> failQ[IDX_SPI_CORRUPT])
        else $error("failure event lost");
    a_wake_set: assert property (
        wakeEvt[IDX_BUS_WAKE]
            |=> wakeFlags[IDX_BUS_WAKE])
        else $error("wake event lost");
    a_cond_follows: assert property (
        clr001 && condNow == '0 && stateEvt == '0
            |=> condQ == '0)
        else $error("condition flags kept after read");
    a_undervolt_falls: assert property (
        prevQ[IDX_AUX_REG_UNDERVOLT] && !condNow[IDX_AUX_REG_UNDERVOLT]
            && !auxRegSwitchingOff |-> stateEvt[IDX_AUX_REG_UNDERVOLT])
        else $error("undervoltage recovery raised no event");
    a_pin_drive_low: assert property (
        irqPinOe |-> !irqPinOut)
        else $error("pin enabled without driving low");
    a_config_capture: assert property (
        initPhase |=> cfgSel == $past(irqPinIn))
        else $error("configuration level not captured");

    c_pulse_released: cover property (
        stateQ == PIN_LOW ##1 stateQ == PIN_GAP);
    c_read_early: cover property (clr000 && stateQ == PIN_LOW);
    c_pending_gap: cover property (stateQ == PIN_GAP && pendQ);
    c_switch_on: cover property (auxRegSwitchOn && modeOk);
    c_stop_pulse: cover property (sysMode == MODE_STOP && stateQ == PIN_LOW);
endmodule

// ### test/host_pin_model.sv
// Purpose: host side of the interrupt pin: pull-up and config strap
// Assumes: pin is open drain, low while the device enables it or the host drives a low strap
// Notes: host drives the strap level only while it is told to
`timescale 1ns/1ps
module host_pin_model (
    input wire logic irqPinOut,   // device drive value
    input wire logic irqPinOe,    // device drives pin
    input wire logic cfgDriveEn,  // host drives strap
    input wire logic cfgLevel,    // strap level
    output logic irqPinIn         // resolved pin level
);
    // ****************************************************************
    // wired pin level
    // ****************************************************************
    always_comb begin
        irqPinIn = 1'h1;
        if (cfgDriveEn) begin
            irqPinIn = cfgLevel;
        end
        if (irqPinOe) begin
            irqPinIn = irqPinIn & irqPinOut;
        end
    end
endmodule

// ### test/sbc_interrupt_logic_tb_top.sv
// Purpose: self-checking bench for the interrupt logic
// Assumes: inputs change on the falling clock edge
// Notes: timeout shortened through TIMEOUT_CYC
`timescale 1ns/1ps
module sbc_interrupt_logic_tb_top;
    import sbc_irq_pkg::*;
    localparam int TO = 3000;
    logic clk_sys = 1'h0;
    logic rst_n = 1'h0;
    sys_mode_type sysMode = MODE_INIT;
    logic reset_out_n = 1'h0;
    logic [WAKE_N-1:0] wakeEvt = '0;
    logic [STATE_N-1:0] condIn = '0;
    logic [FAIL_N-1:0] failEvt = '0;
    logic auxOn = 1'h0;
    logic auxOff = 1'h0;
    logic thirdOn = 1'h0;
    logic thirdOff = 1'h0;
    logic maskWrite = 1'h0;
    logic [SRC_N-1:0] maskData = '0;
    logic rdStrobe = 1'h0;
    logic [2:0] rdCmd = 3'h0;
    logic [2:0] rdAddr = 3'h0;
    logic cfgDriveEn = 1'h1;
    logic cfgLevel = 1'h1;
    logic thirdInh = 1'h0;
    logic irqPinIn, irqPinOut, irqPinOe, cfgSel, summaryFlag;
    logic [SRC_N-1:0] maskOut;
    logic [WAKE_N-1:0] wakeFlags;
    logic [STATE_N-1:0] condFlags;
    logic [FAIL_N-1:0] failFlags;
    int mismatches = 0;
    int n_checks = 0;
    int n;

    always #2.5 clk_sys = ~clk_sys;

    sbc_interrupt_logic #(.TIMEOUT_CYC(TO)) i_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .sysMode(sysMode),
        .reset_out_n(reset_out_n), .wakeEvt(wakeEvt), .condIn(condIn),
        .failEvt(failEvt), .auxRegSwitchOn(auxOn),
        .auxRegSwitchingOff(auxOff), .thirdRegSwitchOn(thirdOn),
        .thirdRegSwitchingOff(thirdOff), .thirdRegInhibit(thirdInh),
        .maskWrite(maskWrite), .maskData(maskData), .rdStrobe(rdStrobe),
        .rdCmd(rdCmd), .rdAddr(rdAddr), .irqPinIn(irqPinIn),
        .irqPinOut(irqPinOut), .irqPinOe(irqPinOe), .cfgSel(cfgSel),
        .maskOut(maskOut), .wakeFlags(wakeFlags),
        .summaryFlag(summaryFlag), .condFlags(condFlags),
        .failFlags(failFlags)
    );

    host_pin_model i_host (
        .irqPinOut(irqPinOut), .irqPinOe(irqPinOe),
        .cfgDriveEn(cfgDriveEn), .cfgLevel(cfgLevel), .irqPinIn(irqPinIn)
    );

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic close_out();
        if (mismatches == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge clk_sys);
    endtask

    task automatic rd(input logic [2:0] cmd, input logic [2:0] addr);
        @(negedge clk_sys);
        rdStrobe = 1'h1;
        rdCmd = cmd;
        rdAddr = addr;
        @(negedge clk_sys);
        rdStrobe = 1'h0;
    endtask

    // k below WAKE_N is a wake event, at or above it a failure event
    task automatic fire(input int k);
        @(negedge clk_sys);
        if (k < WAKE_N) begin
            wakeEvt[k] = 1'h1;
        end else begin
            failEvt[k-WAKE_N] = 1'h1;
        end
        @(negedge clk_sys);
        wakeEvt = '0;
        failEvt = '0;
    endtask

    task automatic wait_oe(input logic val, input int lim, output int c);
        c = 0;
        while (irqPinOe !== val) begin
            if (c >= lim) begin
                chk(irqPinOe, val);
                close_out();
            end
            @(negedge clk_sys);
            c++;
        end
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        cyc(20);
        rst_n = 1'h1;
        cyc(1);
        chk(maskOut, 15'h7FFF);
        chk({irqPinOe, summaryFlag, condFlags, failFlags}, '0);
        fire(IDX_PIN_WAKE);
        chk(irqPinOe, 1'h0);
        chk(cfgSel, 1'h1);
        cfgLevel = 1'h0;
        cyc(2);
        chk({irqPinIn, cfgSel}, 2'h0);
        reset_out_n = 1'h1;
        cfgDriveEn = 1'h0;
        sysMode = MODE_SLEEP;
        fire(IDX_BUS_WAKE);
        chk(irqPinOe, 1'h0);
        chk({irqPinIn, cfgSel}, 2'h2);
        sysMode = MODE_FAILSAFE;
        fire(IDX_PERIODIC_WAKE);
        chk(irqPinOe, 1'h0);
        chk(wakeFlags, 4'hD);
        rd(CMD_READ_ONLY, ADDR_WAKE_SUMMARY);
        chk(wakeFlags, '0);
        sysMode = MODE_NORMAL;
        cyc(2);
        chk(irqPinOe, 1'h0);
        for (int k = 0; k < WAKE_N + FAIL_N; k++) begin
            if (k[0]) begin
                sysMode = MODE_STOP;
            end else begin
                sysMode = MODE_NORMAL;
            end
            fire(k);
            chk(irqPinOe, 1'h1);
            chk({irqPinIn, irqPinOut}, 2'h0);
            rd(3'h3, ADDR_FAILURE);
            chk({failFlags, wakeFlags}, 7'h01 << k);
            rd(CMD_READ_ONLY, ADDR_WAKE_SUMMARY);
            rd(CMD_READ_ONLY, ADDR_FAILURE);
            chk({failFlags, wakeFlags}, '0);
            wait_oe(1'h0, TO, n);
            chk(n + 6 >= IRQ_MIN_PULSE_CYC, 1'h1);
            chk(summaryFlag, 1'h0);
            cyc(TO + 10);
        end
        fire(IDX_BUS_WAKE);
        rd(CMD_READ_ONLY, ADDR_WAKE_SUMMARY);
        wait_oe(1'h0, TO, n);
        condIn[IDX_AUX_REG_OVERTEMP] = 1'h1;
        wait_oe(1'h1, TO + 10, n);
        chk(n + 1 >= TO, 1'h1);
        fire(WAKE_N + IDX_SPI_CORRUPT);
        wait_oe(1'h0, TO + 10, n);
        chk(n + 4 >= TO && n <= TO, 1'h1);
        cyc(TO + 10);
        chk(irqPinOe, 1'h0);
        chk({summaryFlag, condFlags, failFlags}, 12'h811);
        condIn = '0;
        cyc(1);
        chk(condFlags, 8'h02);
        rd(CMD_READ_ONLY, ADDR_CONDITION);
        chk(condFlags, 8'h00);
        cyc(1);
        chk(summaryFlag, 1'h1);
        rd(CMD_READ_ONLY, ADDR_FAILURE);
        cyc(1);
        chk(summaryFlag, 1'h0);
        maskData = 15'h7FFD;
        maskWrite = 1'h1;
        cyc(1);
        maskWrite = 1'h0;
        chk(maskOut, 15'h7FFD);
        fire(IDX_SINGLE_WIRE_WAKE);
        cyc(2);
        chk({irqPinOe, wakeFlags}, 5'h02);
        sysMode = MODE_RESTART;
        cyc(1);
        sysMode = MODE_NORMAL;
        chk(maskOut, 15'h7FFF);
        rd(CMD_READ_ONLY, ADDR_WAKE_SUMMARY);
        condIn[IDX_AUX_REG_UNDERVOLT] = 1'h1;
        cyc(1);
        chk({irqPinOe, condFlags}, 9'h120);
        wait_oe(1'h0, TO + 10, n);
        cyc(TO + 10);
        condIn = '0;
        cyc(1);
        chk(irqPinOe, 1'h1);
        rd(CMD_READ_ONLY, ADDR_CONDITION);
        chk(condFlags, 8'h00);
        rd(CMD_READ_ONLY, ADDR_WAKE_SUMMARY);
        wait_oe(1'h0, TO, n);
        cyc(TO + 10);
        auxOff = 1'h1;
        condIn[IDX_AUX_REG_UNDERVOLT] = 1'h1;
        cyc(3);
        chk({irqPinOe, condFlags}, 9'h020);
        condIn = '0;
        cyc(2);
        auxOff = 1'h0;
        rd(CMD_READ_ONLY, ADDR_CONDITION);
        chk({irqPinOe, condFlags}, 9'h000);
        condIn[IDX_THIRD_REG_UNDERVOLT] = 1'h1;
        thirdOn = 1'h1;
        auxOn = 1'h1;
        cyc(1);
        thirdOn = 1'h0;
        auxOn = 1'h0;
        chk({irqPinOe, condFlags}, 9'h160);
        rd(CMD_READ_ONLY, ADDR_CONDITION);
        chk(condFlags, 8'h40);
        condIn = '0;
        rd(CMD_READ_ONLY, ADDR_CONDITION);
        chk(condFlags, 8'h00);
        rd(CMD_READ_ONLY, ADDR_WAKE_SUMMARY);
        wait_oe(1'h0, TO, n);
        thirdInh = 1'h1;
        condIn[IDX_THIRD_REG_OVERCURRENT] = 1'h1;
        cyc(2);
        chk({irqPinOe, condFlags}, 9'h000);
        thirdInh = 1'h0;
        cyc(1);
        chk(condFlags, 8'h80);
        wait_oe(1'h1, TO + 10, n);
        chk(n + 3 >= TO, 1'h1);
        close_out();
    end
endmodule
